/* rtl/wdc_top.sv */
// watchdog control block: timed change protection, prescaler, modes, apb registers
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module wdc_top #(
   parameter int CNT_W = 21
) (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        wdog_osc_tick,
   input  wire logic        always_on_fuse,
   input  wire logic        irq_vector_taken,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output logic             timeout_irq,
   output logic             sys_reset_req,
   output logic [15:0]      restart_vector,
   output logic             irq_out
);
   logic              rst_q1;
   logic              rst_n;
   logic              change_enable_bit;
   logic [2:0]        change_cnt;
   logic              system_reset_enable_bit;
   logic              timeout_irq_enable;
   logic              timeout_irq_flag;
   logic [3:0]        prescaler_select;
   logic              watchdog_reset_flag;
   logic [CNT_W-1:0]  wdog_cnt;
   logic [1:0]        irq_status;
   logic [1:0]        irq_mask;
   logic              acc;
   logic              wr;
   logic              rd;
   logic [7:0]        wb;
   logic              timeout;
   logic [7:0]        ctrl_view;
   wdc_pkg::wdc_mode_t mode;
   wdc_pkg::wdc_cfg_t  cfg;

   // reset release through two flops; assertion stays asynchronous
   // every register below resets from the released copy, except the cause flag
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_q1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n  <= rst_q1;
      end
   end

   // apb decode; zero wait states
   assign acc = psel && penable;
   assign wr  = acc && pwrite;
   assign rd  = acc && !pwrite;
   assign wb  = pwdata[7:0];

   // effective configuration: fuse locks reset on and interrupt off
   assign cfg.prescale = prescaler_select;
   assign cfg.rst_en   = system_reset_enable_bit || always_on_fuse;
   assign cfg.irq_en   = timeout_irq_enable && !always_on_fuse;
   assign mode = wdc_pkg::wdc_mode_t'({cfg.rst_en, cfg.irq_en});

   // time-out length 2048 << select; reserved codes clamp to the longest
   function automatic logic [CNT_W-1:0] limit_of(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > wdc_pkg::PRESCALE_MAX) ? wdc_pkg::PRESCALE_MAX : sel;
      limit_of = CNT_W'((32'd1 << (wdc_pkg::TIMEOUT_BASE_LOG2 + 32'(s))) - 32'd1);
   endfunction : limit_of

   assign timeout = wdog_osc_tick && (mode != wdc_pkg::WDC_STOPPED)
                    && (wdog_cnt >= limit_of(cfg.prescale));

   // oscillator cycle counter; a kick write or a stop restarts it
   // limitation: shortening the select mid-count can expire at once, so kick first
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdog_cnt <= '0;
      end else if ((wr && paddr == wdc_pkg::KICK_OFFSET) || mode == wdc_pkg::WDC_STOPPED) begin
         wdog_cnt <= '0;
      end else if (wdog_osc_tick) begin
         wdog_cnt <= timeout ? '0 : wdog_cnt + 1'b1;
      end
   end

   // change window: self clears after four system clocks
   // a second opening write inside the window restarts the four-cycle count
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         change_enable_bit <= 1'b0;
         change_cnt        <= '0;
      end else if (wr && paddr == wdc_pkg::CTRL_OFFSET && wb[wdc_pkg::BIT_CHANGE_EN]) begin
         change_enable_bit <= 1'b1;
         change_cnt        <= 3'(wdc_pkg::CHANGE_WINDOW_CYCLES - 1);
      end else if (change_enable_bit) begin
         if (change_cnt == '0) begin
            change_enable_bit <= 1'b0;
         end else begin
            change_cnt <= change_cnt - 1'b1;
         end
      end
   end

   // protected fields: clear of reset enable or prescaler change only inside the window
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         system_reset_enable_bit <= 1'b0;
         prescaler_select        <= 4'h0;
      end else begin
         if (wr && paddr == wdc_pkg::CTRL_OFFSET) begin
            if (wb[wdc_pkg::BIT_RST_EN] || change_enable_bit) begin
               system_reset_enable_bit <= wb[wdc_pkg::BIT_RST_EN];
            end
            if (change_enable_bit) begin
               prescaler_select <= {wb[wdc_pkg::BIT_PRE_MSB], wb[2:0]};
            end
         end
         // placed last so the forced one beats a software clear in the same cycle
         if (watchdog_reset_flag) begin
            system_reset_enable_bit <= 1'b1;
         end
      end
   end

   // interrupt enable and flag; the time-out set wins over any clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         timeout_irq_enable <= 1'b0;
         timeout_irq_flag   <= 1'b0;
      end else begin
         if (wr && paddr == wdc_pkg::CTRL_OFFSET) begin
            timeout_irq_enable <= wb[wdc_pkg::BIT_IRQ_EN];
         end
         if (irq_vector_taken && mode == wdc_pkg::WDC_IRQ_RESET) begin
            timeout_irq_enable <= 1'b0;
         end
         if (timeout && cfg.irq_en) begin
            timeout_irq_flag <= 1'b1;
         end else if (irq_vector_taken
                      || (wr && paddr == wdc_pkg::CTRL_OFFSET && wb[wdc_pkg::BIT_IRQ_FLAG])) begin
            timeout_irq_flag <= 1'b0;
         end
      end
   end

   // reset cause flag survives the watchdog reset it requests; software writes zero to clear
   // set beats the clear when both land in one cycle
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         watchdog_reset_flag <= 1'b0;
      end else if (timeout && cfg.rst_en && !cfg.irq_en) begin
         watchdog_reset_flag <= 1'b1;
      end else if (wr && paddr == wdc_pkg::CAUSE_OFFSET && !wb[wdc_pkg::BIT_CAUSE_WDOG]) begin
         watchdog_reset_flag <= 1'b0;
      end
   end

   // system reset request and restart address
   // restart vector is a constant, registered only so the output comes from a flop
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_reset_req  <= 1'b0;
         restart_vector <= wdc_pkg::RESET_VECTOR;
         timeout_irq    <= 1'b0;
      end else begin
         sys_reset_req  <= timeout && cfg.rst_en && !cfg.irq_en;
         restart_vector <= wdc_pkg::RESET_VECTOR;
         timeout_irq    <= timeout_irq_flag && cfg.irq_en;
      end
   end

   // sticky event bits; a read clears only the bits it returned, so an event
   // landing between the setup and access edges waits for the next read
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= '0;
         irq_mask   <= '0;
         irq_out    <= 1'b0;
      end else begin
         irq_status <= ((rd && paddr == wdc_pkg::IRQ_ST_OFFSET) ? (irq_status & ~prdata[1:0])
                                                                : irq_status)
                       | (timeout && cfg.irq_en ? wdc_pkg::IRQ_EV_TIMEOUT : 2'b00)
                       | (sys_reset_req ? wdc_pkg::IRQ_EV_WDRESET : 2'b00);
         if (wr && paddr == wdc_pkg::IRQ_MSK_OFFSET) begin
            irq_mask <= pwdata[1:0];
         end
         irq_out <= |(irq_status & irq_mask);
      end
   end

   assign ctrl_view = {timeout_irq_flag, cfg.irq_en, prescaler_select[3], change_enable_bit,
                       cfg.rst_en, prescaler_select[2:0]};

   // read data registered at the end of the setup cycle; unmapped addresses answer with an error
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            unique case (paddr)
               wdc_pkg::CTRL_OFFSET:    prdata <= {24'h00_0000, ctrl_view};
               wdc_pkg::CAUSE_OFFSET:   prdata <= {28'h000_0000, watchdog_reset_flag, 3'h0};
               wdc_pkg::IRQ_ST_OFFSET:  prdata <= {30'h0000_0000, irq_status};
               wdc_pkg::IRQ_MSK_OFFSET: prdata <= {30'h0000_0000, irq_mask};
               wdc_pkg::KICK_OFFSET:    prdata <= '0;
               default: begin
                  prdata  <= '0;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule : wdc_top
`default_nettype wire

/* rtl/wdc_pkg.sv */
// package: register map, field layout and timing constants of the watchdog control block
package wdc_pkg;
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] CAUSE_OFFSET  = 12'h004;
   localparam logic [11:0] IRQ_ST_OFFSET = 12'h008;
   localparam logic [11:0] IRQ_MSK_OFFSET = 12'h00C;
   localparam logic [11:0] KICK_OFFSET   = 12'h010;
   localparam int BIT_IRQ_FLAG  = 7;
   localparam int BIT_IRQ_EN    = 6;
   localparam int BIT_PRE_MSB   = 5;
   localparam int BIT_CHANGE_EN = 4;
   localparam int BIT_RST_EN    = 3;
   localparam int BIT_CAUSE_WDOG = 3;
   localparam int CHANGE_WINDOW_CYCLES = 4;
   localparam int TIMEOUT_BASE_LOG2 = 11;
   localparam logic [3:0] PRESCALE_MAX = 4'h9;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] IRQ_EV_TIMEOUT = 2'h1;
   localparam logic [1:0] IRQ_EV_WDRESET = 2'h2;
   typedef enum logic [1:0] {
      WDC_STOPPED   = 2'b00,
      WDC_IRQ       = 2'b01,
      WDC_IRQ_RESET = 2'b11,
      WDC_RESET     = 2'b10
   } wdc_mode_t;
   typedef struct packed {
      logic [3:0] prescale;
      logic       rst_en;
      logic       irq_en;
   } wdc_cfg_t;
endpackage : wdc_pkg

/* bench/wdc_asserts.sv */
// checker: port-level properties of the watchdog control block
`timescale 1ns/10ps
`default_nettype none
module wdc_asserts (
   input wire logic        sys_clk,
   input wire logic        arst_n,
   input wire logic        always_on_fuse,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        timeout_irq,
   input wire logic        sys_reset_req,
   input wire logic [15:0] restart_vector
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_read_done;
      pready && !pwrite;
   endsequence
   property p_answer;
      s_setup |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer in first access cycle");
   property p_ready_once;
      pready |=> !pready;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("ready held too long");
   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
   property p_byte_only;
      s_read_done |-> prdata[31:8] == 24'h00_0000;
   endproperty
   a_byte_only: assert property (p_byte_only) else $error("upper read bits set");
   property p_vector;
      restart_vector == wdc_pkg::RESET_VECTOR;
   endproperty
   a_vector: assert property (p_vector) else $error("restart vector wrong");
   // timeouts are thousands of cycles apart, so a reset request stands alone
   property p_rst_pulse;
      sys_reset_req |=> !sys_reset_req [*8];
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset request not a pulse");
   property p_fuse;
      always_on_fuse [*3] |-> !timeout_irq;
   endproperty
   a_fuse: assert property (p_fuse) else $error("interrupt under always-on fuse");
   property p_irq_first;
      $rose(timeout_irq) |-> !sys_reset_req [*3];
   endproperty
   a_irq_first: assert property (p_irq_first) else $error("reset with first interrupt");
endmodule : wdc_asserts
bind wdc_top wdc_asserts u_chk (.sys_clk, .arst_n, .always_on_fuse, .psel, .penable, .pwrite,
   .paddr, .pready, .prdata, .pslverr, .timeout_irq, .sys_reset_req, .restart_vector);
`default_nettype wire

/* bench/wdc_top_bench.sv */
// testbench: register-level tests of the watchdog control block
`timescale 1ns/10ps
`default_nettype none
module wdc_top_bench;
   logic        sys_clk, arst_n, tick, fuse, vec, psel, penable, pwrite, pready, pslverr, er;
   logic        timeout_irq, sys_reset_req, irq_out;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] restart_vector;
   int          bad_count = 0, n_tests = 0, cnt;
   wdc_top DUT (.sys_clk, .arst_n, .wdog_osc_tick(tick), .always_on_fuse(fuse),
      .irq_vector_taken(vec), .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .timeout_irq, .sys_reset_req, .restart_vector, .irq_out);
   // 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task end_sim;
      $display("compares %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   // pin compare at the falling edge, where registered outputs have settled
   task chk_pin(input bit s, input logic e);
      @(negedge sys_clk);
      chk({31'h000_0000, s ? timeout_irq : irq_out}, {31'h000_0000, e});
      @(posedge sys_clk);
   endtask : chk_pin
   // one apb transfer; an idle edge after it keeps psel from being set twice in a step
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk) penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      if (i == 20) bad_count++;
      if (i == 20) end_sim();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : xfer
   task wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h00_0000, d});
   endtask : wr
   task rdchk(input logic [11:0] a, input logic [7:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rd, {24'h00_0000, e});
   endtask : rdchk
   // bounded wait for the reset request (s=0) or the interrupt (s=1)
   task wait_ev(input bit s, input int lim);
      for (cnt = 0; cnt < lim; cnt++) begin
         @(posedge sys_clk);
         if ((s ? timeout_irq : sys_reset_req) === 1'b1) break;
      end
      if (cnt == lim) bad_count++;
      if (cnt == lim) end_sim();
   endtask : wait_ev
   // main sequence; the oscillator tick runs every cycle so select zero is 2048 cycles
   initial begin
      {tick, fuse, vec, psel, penable, pwrite, arst_n} = 7'h40;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rdchk(wdc_pkg::CTRL_OFFSET, wdc_pkg::CTRL_RESET);
      rdchk(12'h020, 8'h00);
      chk(er, 1'b1);
      wr(wdc_pkg::CTRL_OFFSET, 8'h0D);
      rdchk(wdc_pkg::CTRL_OFFSET, 8'h08);
      $display("test protection done");
      wr(wdc_pkg::CTRL_OFFSET, 8'h18);
      wr(wdc_pkg::CTRL_OFFSET, 8'h05);
      rdchk(wdc_pkg::CTRL_OFFSET, 8'h05);
      wr(wdc_pkg::CTRL_OFFSET, 8'h18);
      rdchk(wdc_pkg::CTRL_OFFSET, 8'h1D);
      rdchk(wdc_pkg::CTRL_OFFSET, 8'h0D);
      wr(wdc_pkg::CTRL_OFFSET, 8'h00);
      rdchk(wdc_pkg::CTRL_OFFSET, 8'h0D);
      $display("test change window done");
      wr(wdc_pkg::CTRL_OFFSET, 8'h18);
      wr(wdc_pkg::CTRL_OFFSET, 8'h08);
      wr(wdc_pkg::KICK_OFFSET, 8'h01);
      wait_ev(1'b0, 3000);
      chk(cnt >= 2040 && cnt <= 2056, 1'b1);
      rdchk(wdc_pkg::CAUSE_OFFSET, 8'h08);
      wr(wdc_pkg::CTRL_OFFSET, 8'h18);
      wr(wdc_pkg::CTRL_OFFSET, 8'h00);
      rdchk(wdc_pkg::CTRL_OFFSET, 8'h08);
      wr(wdc_pkg::CTRL_OFFSET, 8'h18);
      wr(wdc_pkg::CTRL_OFFSET, 8'h29);
      rdchk(wdc_pkg::CTRL_OFFSET, 8'h29);
      wr(wdc_pkg::CTRL_OFFSET, 8'h18);
      wr(wdc_pkg::CTRL_OFFSET, 8'h09);
      wr(wdc_pkg::KICK_OFFSET, 8'h01);
      wait_ev(1'b0, 5000);
      chk(cnt >= 4088 && cnt <= 4104, 1'b1);
      wr(wdc_pkg::CAUSE_OFFSET, 8'h00);
      wr(wdc_pkg::CTRL_OFFSET, 8'h18);
      wr(wdc_pkg::CTRL_OFFSET, 8'h00);
      rdchk(wdc_pkg::CTRL_OFFSET, 8'h00);
      $display("test timeout and reset flag done");
      wr(wdc_pkg::IRQ_MSK_OFFSET, 8'h00);
      chk_pin(1'b0, 1'b0);
      wr(wdc_pkg::IRQ_MSK_OFFSET, 8'h03);
      chk_pin(1'b0, 1'b1);
      rdchk(wdc_pkg::IRQ_ST_OFFSET, 8'h02);
      chk_pin(1'b0, 1'b0);
      $display("test interrupt status done");
      wr(wdc_pkg::CTRL_OFFSET, 8'h40);
      wait_ev(1'b1, 3000);
      rdchk(wdc_pkg::CAUSE_OFFSET, 8'h00);
      wr(wdc_pkg::CTRL_OFFSET, 8'hC0);
      chk_pin(1'b1, 1'b0);
      rdchk(wdc_pkg::CTRL_OFFSET, 8'h40);
      wr(wdc_pkg::CTRL_OFFSET, 8'h48);
      wait_ev(1'b1, 3000);
      rdchk(wdc_pkg::CTRL_OFFSET, 8'hC8);
      vec <= 1'b1;
      @(posedge sys_clk) vec <= 1'b0;
      rdchk(wdc_pkg::CTRL_OFFSET, 8'h08);
      wait_ev(1'b0, 2100);
      rdchk(wdc_pkg::IRQ_ST_OFFSET, 8'h03);
      fuse <= 1'b1;
      wr(wdc_pkg::CTRL_OFFSET, 8'hC8);
      rdchk(wdc_pkg::CTRL_OFFSET, 8'h08);
      $display("test modes done");
      end_sim();
   end
endmodule : wdc_top_bench
`default_nettype wire
